/* design/modfreq_pkg.sv */
// Package of offsets, fields and reset values for the modulation and frequency registers
`default_nettype none
package modfreq_pkg;
   // ************************************************
   // Register offsets
   // ************************************************
   localparam logic [6:0] ADDR_MOD_CTRL = 7'h71;
   localparam logic [6:0] ADDR_DEV_LOW = 7'h72;
   localparam logic [6:0] ADDR_OFS_LOW = 7'h73;
   localparam logic [6:0] ADDR_OFS_HIGH = 7'h74;
   localparam logic [6:0] ADDR_BAND_SEL = 7'h75;
   localparam logic [6:0] ADDR_CARR_HIGH = 7'h76;
   localparam logic [6:0] ADDR_CARR_LOW = 7'h77;
   localparam logic [6:0] ADDR_HOP_CHAN = 7'h79;
   localparam logic [6:0] ADDR_HOP_STEP = 7'h7A;
   // ************************************************
   // Reset values
   // ************************************************
   localparam logic [7:0] RST_MOD_CTRL = 8'h00;
   localparam logic [7:0] RST_DEV_LOW = 8'h20;
   localparam logic [9:0] RST_OFFSET = 10'h000;
   localparam logic [7:0] RST_BAND_SEL = 8'h75;
   localparam logic [7:0] RST_CARR_HIGH = 8'hBB;
   localparam logic [7:0] RST_CARR_LOW = 8'h80;
   localparam logic [7:0] RST_HOP_CHAN = 8'h00;
   localparam logic [7:0] RST_HOP_STEP = 8'h00;
   // ************************************************
   // Field positions
   // ************************************************
   localparam int CLK_ROUTE_HI = 7;
   localparam int CLK_ROUTE_LO = 6;
   localparam int SRC_HI = 5;
   localparam int SRC_LO = 4;
   localparam int INVERT_BIT = 3;
   localparam int DEV_MSB_BIT = 2;
   localparam int KIND_HI = 1;
   localparam int KIND_LO = 0;
   localparam int SIDEBAND_BIT = 6;
   localparam int HIGH_BAND_BIT = 5;
   localparam int BAND_HI = 4;
   localparam int BAND_LO = 0;
   // ************************************************
   // Scale constants
   // ************************************************
   localparam int DEV_STEP_HZ = 625;
   localparam int OFS_STEP_MILLIHZ = 156250;
   localparam int BAND_BASE = 24;
   localparam int CARRIER_DIV = 64000;
   localparam int CARRIER_SCALE_KHZ = 10000;
   localparam int HOP_STEP_KHZ = 10;
   // ************************************************
   // Encodings
   // ************************************************
   typedef enum logic [1:0] {
      ROUTE_NONE = 2'h0, ROUTE_GPIO = 2'h1, ROUTE_SERIAL_OUT = 2'h2, ROUTE_INTERRUPT = 2'h3
   } clock_route_t;
   typedef enum logic [1:0] {
      SRC_GPIO = 2'h0, SRC_SERIAL_IN = 2'h1, SRC_FIFO = 2'h2, SRC_PN9 = 2'h3
   } mod_source_t;
   typedef enum logic [1:0] {
      KIND_CARRIER = 2'h0, KIND_OOK = 2'h1, KIND_FSK = 2'h2, KIND_GFSK = 2'h3
   } mod_kind_t;
endpackage : modfreq_pkg
`default_nettype wire

/* design/modulation_frequency_regs.sv */
// Modulation and frequency register group with data routing and synthesizer settings
//
// Operation
// - tx_clock_route routes TX data clock: none, GPIO, serial out, interrupt pin.
// - modulation_source picks GPIO, serial input, FIFO or PN9 transmit data.
// - data_invert inverts both transmitted and received data.
// - modulation_kind: carrier, OOK, FSK or GFSK.
// - Deviation is 9 bits; MSB in control bit 2, low byte separate.
// - Deviation equals value times 625 Hz.
// - Offset is 10-bit two's complement across low and high registers.
// - Applied offset is 156.25 Hz times (high_band+1) times value.
// - Offset register reads return the latest AFC correction.
// - high_band selects 480-930 MHz when set, 240-479.9 MHz when clear.
// - band_index steps 10 MHz low range, 20 MHz high range.
// - Carrier kHz formula combines band, nominal carrier, offset and hopping.
// - nominal_carrier is 16 bits, high byte then low byte.
// - hop_channel holds the hopping channel, multiplied by hop step.
// - hop_step is in 10 kHz units.
`default_nettype none
module modulation_frequency_regs (
   input wire logic clock,
   input wire logic rst,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [9:0] afc_correction,
   input wire logic afc_valid,
   input wire logic gpio_data_in,
   input wire logic serial_in_pin,
   input wire logic select_n_pin,
   input wire logic fifo_data,
   input wire logic rx_data_raw,
   input wire logic tx_data_clock,
   output logic tx_data,
   output logic rx_data,
   output logic gpio_clock_out,
   output logic serial_out_clock,
   output logic interrupt_n_clock,
   output modfreq_pkg::mod_kind_t modulation_kind,
   output logic [8:0] deviation_value,
   output logic [31:0] deviation_hz,
   output logic [9:0] signed_offset,
   output logic signed [31:0] offset_millihz,
   output logic high_band,
   output logic sideband_choice,
   output logic [4:0] band_index,
   output logic [15:0] nominal_carrier,
   output logic [7:0] hop_channel,
   output logic [7:0] hop_step,
   output logic [31:0] carrier_khz
);
   import modfreq_pkg::*;

   // ************************************************
   // Register storage
   // ************************************************
   logic [7:0] mod_ctrl;
   logic [7:0] dev_low;
   logic [9:0] offset_written;
   logic [9:0] afc_last;
   logic [7:0] band_sel;
   logic [7:0] carr_high;
   logic [7:0] carr_low;
   logic [7:0] hop_chan_reg;
   logic [7:0] hop_step_reg;
   logic [8:0] pn9_state;
   logic pn9_tick;

   // Address match against one offset
   function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
      return a == target;
   endfunction : hit

   // Clock routing code compare, shared by three pins
   function automatic logic routed(input logic [7:0] ctrl, input clock_route_t code);
      return ctrl[CLK_ROUTE_HI:CLK_ROUTE_LO] == code;
   endfunction : routed

   // Nine-bit deviation word from its two registers
   function automatic logic [8:0] dev_word(input logic [7:0] ctrl, input logic [7:0] low);
      return {ctrl[DEV_MSB_BIT], low};
   endfunction : dev_word

   // ************************************************
   // Modulation control and deviation
   // ************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         mod_ctrl <= RST_MOD_CTRL;
      end else if (reg_write && hit(reg_addr, ADDR_MOD_CTRL)) begin
         mod_ctrl <= reg_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         dev_low <= RST_DEV_LOW;
      end else if (reg_write && hit(reg_addr, ADDR_DEV_LOW)) begin
         dev_low <= reg_wdata;
      end
   end

   // ************************************************
   // Frequency offset setting
   // ************************************************
   // Kept apart from AFC result; corrections never overwrite it
   always_ff @(posedge clock) begin
      if (rst) begin
         offset_written <= RST_OFFSET;
      end else if (reg_write) begin
         if (hit(reg_addr, ADDR_OFS_LOW)) begin
            offset_written[7:0] <= reg_wdata;
         end
         if (hit(reg_addr, ADDR_OFS_HIGH)) begin
            offset_written[9:8] <= reg_wdata[1:0];
         end
      end
   end

   // ************************************************
   // Band select and nominal carrier
   // ************************************************
   // Reserved top bit never stored, so it reads back zero
   always_ff @(posedge clock) begin
      if (rst) begin
         band_sel <= RST_BAND_SEL;
      end else if (reg_write && hit(reg_addr, ADDR_BAND_SEL)) begin
         band_sel <= {1'b0, reg_wdata[6:0]};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         carr_high <= RST_CARR_HIGH;
      end else if (reg_write && hit(reg_addr, ADDR_CARR_HIGH)) begin
         carr_high <= reg_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         carr_low <= RST_CARR_LOW;
      end else if (reg_write && hit(reg_addr, ADDR_CARR_LOW)) begin
         carr_low <= reg_wdata;
      end
   end

   // ************************************************
   // Hopping channel and step
   // ************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         hop_chan_reg <= RST_HOP_CHAN;
      end else if (reg_write && hit(reg_addr, ADDR_HOP_CHAN)) begin
         hop_chan_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hop_step_reg <= RST_HOP_STEP;
      end else if (reg_write && hit(reg_addr, ADDR_HOP_STEP)) begin
         hop_step_reg <= reg_wdata;
      end
   end

   // ************************************************
   // AFC result capture
   // ************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         afc_last <= RST_OFFSET;
      end else if (afc_valid) begin
         afc_last <= afc_correction;
      end
   end

   // ************************************************
   // Read port
   // ************************************************
   // Offset reads show AFC, not the stored setting
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         case (reg_addr)
            ADDR_MOD_CTRL: reg_rdata <= mod_ctrl;
            ADDR_DEV_LOW: reg_rdata <= dev_low;
            ADDR_OFS_LOW: reg_rdata <= afc_last[7:0];
            ADDR_OFS_HIGH: reg_rdata <= {6'h00, afc_last[9:8]};
            ADDR_BAND_SEL: reg_rdata <= band_sel;
            ADDR_CARR_HIGH: reg_rdata <= carr_high;
            ADDR_CARR_LOW: reg_rdata <= carr_low;
            ADDR_HOP_CHAN: reg_rdata <= hop_chan_reg;
            ADDR_HOP_STEP: reg_rdata <= hop_step_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // ************************************************
   // PN9 generator
   // ************************************************
   // Advances once per rising TX data clock edge
   logic tx_clk_prev;
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_clk_prev <= 1'b0;
         pn9_state <= 9'h1FF;
      end else begin
         tx_clk_prev <= tx_data_clock;
         if (pn9_tick) pn9_state <= {pn9_state[7:0], pn9_state[8] ^ pn9_state[4]};
      end
   end
   assign pn9_tick = tx_data_clock & ~tx_clk_prev;

   // ************************************************
   // Data routing
   // ************************************************
   logic next_tx;
   always_comb begin
      case (mod_source_t'(mod_ctrl[SRC_HI:SRC_LO]))
         SRC_GPIO: next_tx = gpio_data_in;
         SRC_SERIAL_IN: next_tx = select_n_pin ? serial_in_pin : 1'b0;
         SRC_FIFO: next_tx = fifo_data;
         SRC_PN9: next_tx = pn9_state[8];
         default: next_tx = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tx_data <= 1'b0;
         rx_data <= 1'b0;
      end else begin
         tx_data <= next_tx ^ mod_ctrl[INVERT_BIT];
         rx_data <= rx_data_raw ^ mod_ctrl[INVERT_BIT];
      end
   end

   // Clock only reaches the selected pin; others idle
   always_ff @(posedge clock) begin
      if (rst) begin
         gpio_clock_out <= 1'b0;
         serial_out_clock <= 1'b0;
         interrupt_n_clock <= 1'b1;
      end else begin
         gpio_clock_out <= routed(mod_ctrl, ROUTE_GPIO) & tx_data_clock;
         serial_out_clock <= routed(mod_ctrl, ROUTE_SERIAL_OUT) & tx_data_clock;
         interrupt_n_clock <= routed(mod_ctrl, ROUTE_INTERRUPT) ? tx_data_clock : 1'b1;
      end
   end

   // ************************************************
   // Synthesizer settings
   // ************************************************
   logic signed [31:0] ofs_ext;
   logic signed [31:0] carr_sum;
   logic [31:0] band_mult;
   logic signed [63:0] frac_term;
   logic signed [63:0] frac_div;
   logic [63:0] band_term;
   logic [63:0] hop_term;
   logic [63:0] carrier_calc;
   // Band factor applied before the divide; dividing first drops up to one kHz
   always_comb begin
      ofs_ext = 32'(signed'(offset_written));
      carr_sum = signed'({16'h0, carr_high, carr_low}) + ofs_ext;
      band_mult = {31'h0, band_sel[HIGH_BAND_BIT]} + 32'h1;
      frac_term = 64'(carr_sum) * 64'(CARRIER_SCALE_KHZ)
         * 64'(signed'(band_mult));
      frac_div = frac_term / 64'(CARRIER_DIV);
      band_term = (64'(band_sel[BAND_HI:BAND_LO]) + 64'(BAND_BASE))
         * 64'(CARRIER_SCALE_KHZ) * 64'(band_mult);
      hop_term = 64'(hop_chan_reg) * 64'(hop_step_reg) * 64'(HOP_STEP_KHZ);
      carrier_calc = 64'(frac_div) + band_term + hop_term;
   end

   // ************************************************
   // Modulation outputs
   // ************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         modulation_kind <= KIND_CARRIER;
         deviation_value <= {RST_MOD_CTRL[DEV_MSB_BIT], RST_DEV_LOW};
         deviation_hz <= 32'({RST_MOD_CTRL[DEV_MSB_BIT], RST_DEV_LOW}) * 32'(DEV_STEP_HZ);
      end else begin
         modulation_kind <= mod_kind_t'(mod_ctrl[KIND_HI:KIND_LO]);
         deviation_value <= dev_word(mod_ctrl, dev_low);
         deviation_hz <= 32'(dev_word(mod_ctrl, dev_low)) * 32'(DEV_STEP_HZ);
      end
   end

   // ************************************************
   // Offset outputs
   // ************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         signed_offset <= RST_OFFSET;
         offset_millihz <= 32'sh0;
      end else begin
         signed_offset <= offset_written;
         offset_millihz <= ofs_ext * 32'(OFS_STEP_MILLIHZ) * signed'(band_mult);
      end
   end

   // ************************************************
   // Band, carrier and hopping outputs
   // ************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         high_band <= RST_BAND_SEL[HIGH_BAND_BIT];
         sideband_choice <= RST_BAND_SEL[SIDEBAND_BIT];
         band_index <= RST_BAND_SEL[BAND_HI:BAND_LO];
         nominal_carrier <= {RST_CARR_HIGH, RST_CARR_LOW};
      end else begin
         high_band <= band_sel[HIGH_BAND_BIT];
         sideband_choice <= band_sel[SIDEBAND_BIT];
         band_index <= band_sel[BAND_HI:BAND_LO];
         nominal_carrier <= {carr_high, carr_low};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hop_channel <= RST_HOP_CHAN;
         hop_step <= RST_HOP_STEP;
      end else begin
         hop_channel <= hop_chan_reg;
         hop_step <= hop_step_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         carrier_khz <= 32'h0;
      end else begin
         carrier_khz <= carrier_calc[31:0];
      end
   end
endmodule : modulation_frequency_regs
`default_nettype wire

/* tb/modfreq_checker.sv */
// Checker for data routing and deviation settings at the block's ports
`default_nettype none
module modfreq_checker
   import modfreq_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic reg_write,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic rx_data_raw,
   input wire logic fifo_data,
   input wire logic gpio_data_in,
   input wire logic serial_in_pin,
   input wire logic serial_out_clock,
   input wire logic tx_data_clock,
   input wire logic select_n_pin,
   input wire logic rx_data,
   input wire logic tx_data,
   input wire logic gpio_clock_out,
   input wire logic interrupt_n_clock,
   input wire logic [8:0] deviation_value,
   input wire logic [31:0] deviation_hz
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl;
   logic armed;
   wire inv = ctl[INVERT_BIT];
   wire [1:0] src = ctl[SRC_HI:SRC_LO];
   wire [1:0] route = ctl[CLK_ROUTE_HI:CLK_ROUTE_LO];
   // Copy of the control register, rebuilt from the write strobes
   always_ff @(posedge clock) begin
      if (rst) ctl <= RST_MOD_CTRL;
      else if (reg_write && reg_addr == ADDR_MOD_CTRL) ctl <= reg_wdata;
   end
   // Outputs still show reset values one edge after release
   always_ff @(posedge clock) armed <= !rst;
   default clocking @(posedge clock); endclocking
   default disable iff (rst || !armed);
   sequence s_dev_write;
      reg_write && reg_addr == ADDR_DEV_LOW;
   endsequence
   a_rx_invert: assert property (rx_data == $past(rx_data_raw ^ inv))
      else $error("rx_data is not raw data xor invert bit");
   a_fifo_path: assert property (src == SRC_FIFO |=> tx_data == $past(fifo_data ^ inv))
      else $error("fifo data not routed to tx_data");
   a_serial_gate: assert property (src == SRC_SERIAL_IN && !select_n_pin
      |=> tx_data == $past(inv)) else $error("serial data passed while selected");
   a_gpio_path: assert property (src == SRC_GPIO |=> tx_data == $past(gpio_data_in ^ inv))
      else $error("gpio data not routed to tx_data");
   a_serial_pass: assert property (src == SRC_SERIAL_IN && select_n_pin
      |=> tx_data == $past(serial_in_pin ^ inv)) else $error("serial data not passed");
   a_gpio_route: assert property (gpio_clock_out == $past(tx_data_clock && route == 1))
      else $error("gpio clock output wrong");
   a_sdo_route: assert property (serial_out_clock == $past(tx_data_clock && route == 2))
      else $error("serial output clock wrong");
   a_irq_route: assert property (interrupt_n_clock ==
      $past(tx_data_clock || route != 3)) else $error("interrupt pin clock output wrong");
   a_dev_scale: assert property (deviation_hz == deviation_value * DEV_STEP_HZ)
      else $error("deviation in hertz wrong");
   a_dev_msb: assert property (deviation_value[8] == $past(ctl[DEV_MSB_BIT]))
      else $error("deviation top bit wrong");
   a_dev_write: assert property (s_dev_write |-> ##2
      deviation_value[7:0] == $past(reg_wdata, 2)) else $error("deviation low byte not taken");
endmodule : modfreq_checker
`default_nettype wire

/* tb/host_model.sv */
// Host controller model driving register strobes and serial data pins
`default_nettype none
module host_model (
   input wire logic clock,
   input wire logic [7:0] reg_rdata,
   output logic reg_write,
   output logic reg_read,
   output logic [6:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic serial_in_pin,
   output logic select_n_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
      serial_in_pin = 1'b0;
      select_n_pin = 1'b1;
   end
   // Address and data scrambled after use so stale values never look valid
   task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_write = wr;
      reg_read = !wr;
      @(negedge clock);
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      @(negedge clock);
      q = reg_rdata;
   endtask : access
   task automatic put_serial(input logic sel_n, input logic d);
      @(negedge clock);
      select_n_pin = sel_n;
      serial_in_pin = d;
   endtask : put_serial
endmodule : host_model
`default_nettype wire

/* tb/tb_top.sv */
// Bench: reset values, register table, mode codes, offset readback, serial gating
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import modfreq_pkg::*;
   logic clock, rst, reg_write, reg_read, serial_in_pin, select_n_pin, afc_valid;
   logic tx_data, rx_data, high_band, sideband_choice;
   logic [3:0] act;
   logic [4:0] band_index;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, hop_channel, hop_step, q;
   logic [8:0] deviation_value;
   logic [9:0] afc_correction, signed_offset;
   logic [15:0] nominal_carrier;
   logic [31:0] deviation_hz, carrier_khz;
   logic signed [31:0] offset_millihz;
   logic [23:0] r;
   mod_kind_t modulation_kind;
   int fails, checked;
   // Address, write flag, data written, data read back
   localparam logic [23:0] ROWS [17] = '{{7'h71, 1'b0, 16'h0000}, {7'h72, 1'b0, 16'h0020},
      {7'h73, 1'b0, 16'h0000}, {7'h74, 1'b0, 16'h0000}, {7'h75, 1'b0, 16'h0075},
      {7'h76, 1'b0, 16'h00BB}, {7'h77, 1'b0, 16'h0080}, {7'h79, 1'b0, 16'h0000},
      {7'h7A, 1'b0, 16'h0000}, {7'h72, 1'b1, 16'h4040}, {7'h75, 1'b1, 16'hFF7F},
      {7'h76, 1'b1, 16'h1212}, {7'h77, 1'b1, 16'h3030}, {7'h79, 1'b1, 16'h0707},
      {7'h7A, 1'b1, 16'h0303}, {7'h60, 1'b1, 16'hAA00}, {7'h71, 1'b1, 16'h0404}};
   modulation_frequency_regs dut_u (.clock, .rst, .reg_write, .reg_read, .reg_addr,
      .reg_wdata, .reg_rdata, .afc_correction, .afc_valid, .gpio_data_in(act[3]),
      .serial_in_pin, .select_n_pin, .fifo_data(act[1]), .rx_data_raw(act[2]),
      .tx_data_clock(act[0]), .tx_data, .rx_data, .gpio_clock_out(), .serial_out_clock(),
      .interrupt_n_clock(), .modulation_kind, .deviation_value, .deviation_hz,
      .signed_offset, .offset_millihz, .high_band, .sideband_choice, .band_index,
      .nominal_carrier, .hop_channel, .hop_step, .carrier_khz);
   host_model host_u (.clock, .reg_rdata, .reg_write, .reg_read, .reg_addr, .reg_wdata,
      .serial_in_pin, .select_n_pin);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Free-running data and clock activity keeps the GPIO, FIFO, receive and TX clock paths busy
   always @(negedge clock) act <= act + 4'h1;
   initial begin
      repeat (5000) @(posedge clock);
      fails++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      act = 4'h0;
      afc_valid = 1'b0;
      afc_correction = 10'h000;
      repeat (16) @(negedge clock);
      rst = 1'b0;
      foreach (ROWS[i]) begin
         r = ROWS[i];
         if (r[16]) host_u.access(1'b1, r[23:17], r[15:8], q);
         host_u.access(1'b0, r[23:17], 8'h00, q);
         check(q, r[7:0]);
      end
      check(deviation_value, 9'h140);
      check(deviation_hz, 32'h00030D40);
      check({sideband_choice, high_band, band_index}, 7'h7F);
      check({nominal_carrier, hop_channel, hop_step}, 32'h12300703);
      check(carrier_khz, 32'h0010CF61);
      host_u.access(1'b1, ADDR_OFS_LOW, 8'hF0, q);
      host_u.access(1'b1, ADDR_OFS_HIGH, 8'h03, q);
      check(signed_offset, 10'h3F0);
      check(offset_millihz, 32'hFFB3B4C0);
      check(carrier_khz, 32'h0010CF5C);
      host_u.access(1'b1, ADDR_BAND_SEL, 8'h41, q);
      check(offset_millihz, 32'hFFD9DA60);
      check(carrier_khz, 32'h0003D437);
      @(negedge clock);
      afc_correction = 10'h2A5;
      afc_valid = 1'b1;
      @(negedge clock);
      afc_valid = 1'b0;
      afc_correction = 10'h15A;
      host_u.access(1'b0, ADDR_OFS_LOW, 8'h00, q);
      check(q, 8'hA5);
      host_u.access(1'b0, ADDR_OFS_HIGH, 8'h00, q);
      check(q, 8'h02);
      check(signed_offset, 10'h3F0);
      // GFSK only pairs with PN9 here; the GPIO source direct mode runs with no clock route
      for (int i = 0; i < 4; i++) begin
         host_u.access(1'b1, ADDR_MOD_CTRL, {i[1:0], i[1:0], i[0], 1'b0, i[1:0]}, q);
         repeat (8) @(negedge clock);
         check(modulation_kind, i[1:0]);
      end
      host_u.access(1'b1, ADDR_MOD_CTRL, 8'h18, q);
      host_u.put_serial(1'b0, 1'b1);
      repeat (2) @(negedge clock);
      check(tx_data, 1'b1);
      host_u.put_serial(1'b1, 1'b1);
      repeat (2) @(negedge clock);
      check(tx_data, 1'b0);
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      host_u.access(1'b0, ADDR_BAND_SEL, 8'h00, q);
      check(q, RST_BAND_SEL);
      check(deviation_value, 9'h020);
      report_and_stop();
   end
endmodule : tb_top
bind modulation_frequency_regs modfreq_checker chk_u (.clock, .rst, .reg_write, .reg_addr,
   .reg_wdata, .rx_data_raw, .fifo_data, .gpio_data_in, .serial_in_pin, .serial_out_clock,
   .tx_data_clock, .select_n_pin, .rx_data, .tx_data,
   .gpio_clock_out, .interrupt_n_clock, .deviation_value, .deviation_hz);
`default_nettype wire
